// ---- aclr_top.sv ----
// Purpose: APB register bank staging per-port ACL rule bytes
// Assumes: One clock, synchronous active-low reset
// Notes:   Access phase always takes two cycles
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "aclr_cfg.svh"

module aclr_top #(
  parameter int NPORTS = `ACLR_NPORTS
) (
  // Clock and reset
  input  wire logic                                  i_clk,
  input  wire logic                                  i_nrst,
  // APB slave
  input  wire logic                                  i_psel,
  input  wire logic                                  i_penable,
  input  wire logic                                  i_pwrite,
  input  wire logic [`ACLR_PADDR_W-1:0]              i_paddr,
  input  wire logic [31:0]                           i_pwdata,
  input  wire logic [3:0]                            i_pstrb,
  output logic      [31:0]                           o_prdata,
  output logic                                       o_pready,
  output logic                                       o_pslverr,
  // Staged rule fields, index 0 is port 1
  output aclr_pkg::aclr_rule_fields_t [NPORTS-1:0]   o_rule_fields
);

  // ==========================================================
  // Transfer sequencing
  typedef enum logic {
    ST_IDLE,
    ST_ACK
  } aclr_state_t;

  aclr_state_t            state_q;
  aclr_pkg::aclr_apb_req_t req;
  logic                   access;
  logic                   hit_tsel;
  logic                   hit_offset;
  logic                   hit_data;
  logic                   mapped;
  logic                   commit;

  assign req.idx   = i_paddr[`ACLR_PADDR_W-1:2];
  assign req.write = i_pwrite;
  assign req.lane0 = i_pstrb[0];
  assign req.wbyte = i_pwdata[7:0];

  assign access     = i_psel && i_penable;
  assign hit_tsel   = (req.idx == `ACLR_IDX_TSEL);
  assign hit_offset = (req.idx == `ACLR_IDX_OFFSET);
  assign hit_data   = (req.idx == `ACLR_IDX_DATA);
  assign mapped     = hit_tsel || hit_offset || hit_data;
  // Writes land only at the edge where pready is sampled high
  assign commit     = (state_q == ST_ACK) && access && req.write && req.lane0 && !o_pslverr;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (access) begin
            state_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= (state_q == ST_IDLE) && access;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_pslverr <= 1'b0;
    end else if ((state_q == ST_IDLE) && access) begin
      o_pslverr <= !mapped;
    end else begin
      o_pslverr <= 1'b0;
    end
  end

  // ==========================================================
  // Select registers
  logic [7:0] tsel_q;
  logic [7:0] offset_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      tsel_q <= `ACLR_RST_BYTE;
    end else if (commit && hit_tsel) begin
      tsel_q <= req.wbyte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      offset_q <= `ACLR_RST_BYTE;
    end else if (commit && hit_offset) begin
      offset_q <= req.wbyte;
    end
  end

  // ==========================================================
  // Target decode
  logic              acl_sel;
  logic [NPORTS-1:0] port_hit;
  logic              off_valid;
  logic [3:0]        off_idx;
  logic              target_ok;

  aclr_sel_dec #(
    .NPORTS      (NPORTS)
  ) u_dec (
    .i_tsel      (tsel_q),
    .i_offset    (offset_q),
    .o_acl_sel   (acl_sel),
    .o_port_hit  (port_hit),
    .o_off_valid (off_valid),
    .o_off_idx   (off_idx)
  );

  // Other tables and bad ports stage nothing here
  assign target_ok = acl_sel && off_valid && (|port_hit);

  // ==========================================================
  // Per-port rule entries
  logic [NPORTS-1:0] port_we;
  logic [7:0]        port_rdata [NPORTS];
  logic [7:0]        sel_byte;

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      assign port_we[g] = commit && hit_data && target_ok && port_hit[g];

      aclr_entry #(
        .NBYTES   (`ACLR_ENTRY_BYTES)
      ) u_entry (
        .i_clk    (i_clk),
        .i_nrst   (i_nrst),
        .i_we     (port_we[g]),
        .i_off    (off_idx),
        .i_wdata  (req.wbyte),
        .o_rdata  (port_rdata[g]),
        .o_fields (o_rule_fields[g])
      );
    end
  endgenerate

  always_comb begin
    sel_byte = `ACLR_RST_BYTE;
    for (int i = 0; i < NPORTS; i++) begin
      if (target_ok && port_hit[i]) begin
        sel_byte = port_rdata[i];
      end
    end
  end

  // ==========================================================
  // Read data, captured with pready
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_prdata <= `ACLR_RST_WORD;
    end else if ((state_q == ST_IDLE) && access && !req.write) begin
      if (hit_tsel) begin
        o_prdata <= {24'h000000, tsel_q};
      end else if (hit_offset) begin
        o_prdata <= {24'h000000, offset_q};
      end else if (hit_data) begin
        o_prdata <= {24'h000000, sel_byte};
      end else begin
        o_prdata <= `ACLR_RST_WORD;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_data_commit(int p, logic [3:0] off);
    port_we[p] && (off_idx == off);
  endsequence

  sequence s_read_start;
    (state_q == ST_IDLE) && access && !req.write && hit_data;
  endsequence

  a_access_answer: assert property (
    (access && !o_pready && state_q == ST_IDLE) |=> o_pready ##1 !o_pready)
    else $error("pready did not answer in one cycle");

  a_data_read_value: assert property (
    s_read_start |=> (o_pready && o_prdata[7:0] == $past(sel_byte) && o_prdata[31:8] == 24'h000000))
    else $error("data byte read mismatch");

  a_table_route: assert property (
    (|port_we) |-> (tsel_q[7:5] == 3'h2))
    else $error("entry written without ACL table selected");

  a_port_select: assert property (
    (|port_we) |-> ($onehot(port_we) && tsel_q[3:0] >= 4'h1 && tsel_q[3:0] <= 4'h5))
    else $error("bad port write strobe");

  a_offset_range: assert property (
    (|port_we) |-> (offset_q < 8'h0E && off_idx == offset_q[3:0]))
    else $error("entry written at bad offset");

  a_offset_write: assert property (
    (commit && hit_offset) |=> (offset_q == $past(req.wbyte)) ##1 (state_q == ST_IDLE))
    else $error("offset register not updated");

  generate
    for (g = 0; g < NPORTS; g++) begin : g_chk
      a_mask_high: assert property (
        s_data_commit(g, 4'h8) |=> (o_rule_fields[g].l3_mask_low[15:8] == $past(req.wbyte)))
        else $error("mask high byte not stored");

      a_mask_low: assert property (
        s_data_commit(g, 4'h9) |=> (o_rule_fields[g].l3_mask_low[7:0] == $past(req.wbyte)))
        else $error("mask low byte not stored");

      a_upper_high: assert property (
        s_data_commit(g, 4'h2) |=> (o_rule_fields[g].upper_bound[15:8] == $past(req.wbyte)))
        else $error("upper bound high byte not stored");

      a_upper_low: assert property (
        s_data_commit(g, 4'h3) |=> (o_rule_fields[g].upper_bound[7:0] == $past(req.wbyte)))
        else $error("upper bound low byte not stored");

      a_lower_bytes: assert property (
        (s_data_commit(g, 4'h4) |=> (o_rule_fields[g].lower_bound[15:8] == $past(req.wbyte))) and
        (s_data_commit(g, 4'h5) |=> (o_rule_fields[g].lower_bound[7:0] == $past(req.wbyte))))
        else $error("lower bound byte not stored");

      a_rsvd_zero: assert property (
        (o_rule_fields[g].l4_mode && port_hit[g] && acl_sel && off_idx == 4'h6) |-> (port_rdata[g][7:3] == 5'h00))
        else $error("reserved compare bits not zero");

      a_l4_flag: assert property (
        s_data_commit(g, 4'h1) |=> (o_rule_fields[g].l4_mode == ($past(req.wbyte[5:4]) == 2'h2)))
        else $error("layer-4 flag not updated");

      a_cmp_select: assert property (
        (s_data_commit(g, 4'h6) ##0 o_rule_fields[g].l4_mode) |=>
          (o_rule_fields[g].range_compare_select == aclr_pkg::aclr_cmp_t'($past(req.wbyte[2:1]))))
        else $error("compare select not stored");

      a_hold_other: assert property (
        !port_we[g] |=> $stable(o_rule_fields[g]))
        else $error("unselected port entry changed");
    end
  endgenerate

  // ==========================================================
  // Bus protocol and refusal checks
  sequence s_setup_taken;
    (state_q == ST_IDLE) && access;
  endsequence

  sequence s_write_done;
    (state_q == ST_ACK) && access && req.write;
  endsequence

  a_ready_single: assert property (
    o_pready |=> !o_pready)
    else $error("pready held longer than one cycle");

  a_ready_needs_access: assert property (
    o_pready |-> (state_q == ST_ACK))
    else $error("pready without a taken transfer");

  a_unmapped_error: assert property (
    (s_setup_taken ##0 (!mapped && !req.write)) |=> (o_pready && o_pslverr && o_prdata == 32'h0000_0000))
    else $error("unmapped read not flagged");

  a_mapped_no_error: assert property (
    (s_setup_taken ##0 mapped) |=> (o_pready && !o_pslverr))
    else $error("mapped access flagged as error");

  a_error_only_ready: assert property (
    o_pslverr |-> o_pready)
    else $error("pslverr without pready");

  a_tsel_readback: assert property (
    (s_setup_taken ##0 (!req.write && hit_tsel)) |=> (o_prdata == {24'h000000, $past(tsel_q)}))
    else $error("table select read mismatch");

  a_tsel_write: assert property (
    (s_write_done ##0 (hit_tsel && req.lane0)) |=> (tsel_q == $past(req.wbyte)))
    else $error("table select not updated");

  a_offset_readback: assert property (
    (s_setup_taken ##0 (!req.write && hit_offset)) |=> (o_prdata == {24'h000000, $past(offset_q)}))
    else $error("offset read mismatch");

  a_lane_ignored: assert property (
    (s_write_done ##0 !req.lane0) |=> ($stable(tsel_q) && $stable(offset_q) && $stable(o_rule_fields)))
    else $error("write without lane 0 took effect");

  a_refused_write: assert property (
    (s_write_done ##0 (hit_data && !target_ok)) |=> $stable(o_rule_fields))
    else $error("refused data write changed an entry");

  a_refused_read: assert property (
    (s_setup_taken ##0 (!req.write && hit_data && !target_ok)) |=> (o_prdata == 32'h0000_0000))
    else $error("refused data read not zero");

  a_select_hold: assert property (
    !(commit && (hit_tsel || hit_offset)) |=> ($stable(tsel_q) && $stable(offset_q)))
    else $error("select register changed without write");

  a_reset_clear: assert property (
    @(posedge i_clk) disable iff (1'b0)
    !i_nrst |=> (o_rule_fields[0].upper_bound == 16'h0000 && o_rule_fields[0].lower_bound == 16'h0000
                 && o_rule_fields[0].l3_mask_low == 16'h0000 && !o_pready))
    else $error("state not cleared by reset");

endmodule
`default_nettype wire

// ---- aclr_cfg.svh ----
// Purpose: Constants for the ACL rule staging register bank
// Assumes: APB byte address = 4 * register index
// Notes:   Included by its bare name
`ifndef ACLR_CFG_SVH
`define ACLR_CFG_SVH

// ==========================================================
// Bus geometry
`define ACLR_PADDR_W      12
`define ACLR_IDX_W        10
`define ACLR_IDX_TSEL     10'h06E
`define ACLR_IDX_OFFSET   10'h06F
`define ACLR_IDX_DATA     10'h0A0

// ==========================================================
// Table and port select fields
`define ACLR_TSEL_TBL_HI  7
`define ACLR_TSEL_TBL_LO  5
`define ACLR_TSEL_ACL     3'h2
`define ACLR_TSEL_PORT_HI 3
`define ACLR_TSEL_PORT_LO 0
`define ACLR_PORT_FIRST   4'h1
`define ACLR_NPORTS       5

// ==========================================================
// Rule entry layout
`define ACLR_ENTRY_BYTES  14
`define ACLR_OFF_MODE     4'h1
`define ACLR_OFF_UPPER_HI 4'h2
`define ACLR_OFF_UPPER_LO 4'h3
`define ACLR_OFF_LOWER_HI 4'h4
`define ACLR_OFF_LOWER_LO 4'h5
`define ACLR_OFF_CMP      4'h6
`define ACLR_OFF_MASK_HI  4'h8
`define ACLR_OFF_MASK_LO  4'h9
`define ACLR_MODE_HI      5
`define ACLR_MODE_LO      4
`define ACLR_MODE_L4      2'h2
`define ACLR_CMP_HI       2
`define ACLR_CMP_LO       1
`define ACLR_CMP_RSVD     8'hF8

// ==========================================================
// Reset values
`define ACLR_RST_BYTE     8'h00
`define ACLR_RST_WORD     32'h0000_0000

`endif

// ---- aclr_pkg.sv ----
// Purpose: Types shared by the ACL rule staging bank
// Assumes: Constants live in aclr_cfg.svh
// Notes:   Nothing is imported by users
package aclr_pkg;

  // ==========================================================
  // Port comparison modes
  typedef enum logic [1:0] {
    CMP_OFF,
    CMP_EITHER,
    CMP_INSIDE,
    CMP_OUTSIDE
  } aclr_cmp_t;

  // ==========================================================
  // Decoded fields of one staged rule
  typedef struct packed {
    logic             l4_mode;
    logic [15:0]      l3_mask_low;
    logic [15:0]      upper_bound;
    logic [15:0]      lower_bound;
    aclr_cmp_t        range_compare_select;
  } aclr_rule_fields_t;

  // ==========================================================
  // APB request fields, taken straight from the bus inputs
  typedef struct packed {
    logic [9:0]       idx;
    logic             write;
    logic             lane0;
    logic [7:0]       wbyte;
  } aclr_apb_req_t;

endpackage

// ---- aclr_sel_dec.sv ----
// Purpose: Decode table select, port and byte offset
// Assumes: Inputs come from registers on the same clock
// Notes:   Purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "aclr_cfg.svh"

module aclr_sel_dec #(
  parameter int NPORTS = `ACLR_NPORTS
) (
  // Select registers
  input  wire logic [7:0]        i_tsel,
  input  wire logic [7:0]        i_offset,
  // Decoded target
  output logic                   o_acl_sel,
  output logic [NPORTS-1:0]      o_port_hit,
  output logic                   o_off_valid,
  output logic [3:0]             o_off_idx
);

  logic [3:0] port_num;

  assign port_num    = i_tsel[`ACLR_TSEL_PORT_HI:`ACLR_TSEL_PORT_LO];
  assign o_acl_sel   = (i_tsel[`ACLR_TSEL_TBL_HI:`ACLR_TSEL_TBL_LO] == `ACLR_TSEL_ACL);
  assign o_off_valid = (i_offset < 8'(`ACLR_ENTRY_BYTES));
  assign o_off_idx   = i_offset[3:0];

  // Ports outside 1..NPORTS hit nothing
  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_hit
      assign o_port_hit[g] = (port_num == 4'(g + 1));
    end
  endgenerate

endmodule
`default_nettype wire

// ---- aclr_entry.sv ----
// Purpose: Byte storage of one port's staged rule
// Assumes: Write strobe is one cycle per byte
// Notes:   Byte 0x06 hides bits 7:3 under layer-4 mode
`timescale 1ns/1ps
`default_nettype none
`include "aclr_cfg.svh"

module aclr_entry #(
  parameter int NBYTES = `ACLR_ENTRY_BYTES
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  // Byte access
  input  wire logic                      i_we,
  input  wire logic [3:0]                i_off,
  input  wire logic [7:0]                i_wdata,
  output logic      [7:0]                o_rdata,
  // Decoded fields
  output aclr_pkg::aclr_rule_fields_t    o_fields
);

  logic [7:0] mem_q [NBYTES];
  logic       l4_mode_q;
  logic [7:0] wmask;

  // Mode kept in its own flop so the field output is registered
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      l4_mode_q <= 1'b0;
    end else if (i_we && i_off == `ACLR_OFF_MODE) begin
      l4_mode_q <= (i_wdata[`ACLR_MODE_HI:`ACLR_MODE_LO] == `ACLR_MODE_L4);
    end
  end

  // Reserved bits not stored in layer-4 mode, so they cannot reappear later
  assign wmask   = (l4_mode_q && i_off == `ACLR_OFF_CMP) ? ~`ACLR_CMP_RSVD : 8'hFF;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      for (int i = 0; i < NBYTES; i++) begin
        mem_q[i] <= `ACLR_RST_BYTE;
      end
    end else if (i_we) begin
      mem_q[i_off] <= i_wdata & wmask;
    end
  end

  always_comb begin
    o_rdata = mem_q[i_off];
    if (l4_mode_q && i_off == `ACLR_OFF_CMP) begin
      o_rdata = mem_q[i_off] & ~`ACLR_CMP_RSVD;
    end
  end

  assign o_fields.l4_mode              = l4_mode_q;
  assign o_fields.l3_mask_low          = {mem_q[`ACLR_OFF_MASK_HI], mem_q[`ACLR_OFF_MASK_LO]};
  assign o_fields.upper_bound          = {mem_q[`ACLR_OFF_UPPER_HI], mem_q[`ACLR_OFF_UPPER_LO]};
  assign o_fields.lower_bound          = {mem_q[`ACLR_OFF_LOWER_HI], mem_q[`ACLR_OFF_LOWER_LO]};
  assign o_fields.range_compare_select =
    aclr_pkg::aclr_cmp_t'(mem_q[`ACLR_OFF_CMP][`ACLR_CMP_HI:`ACLR_CMP_LO]);

endmodule
`default_nettype wire

// ---- aclr_top_bench.sv ----
// Purpose: Self-checking bench for the ACL rule staging register bank
// Assumes: APB master, one 10 MHz clock, synchronous active-low reset
// Notes:   Driver queues expectations, monitor checks them on pready
`timescale 1ns/1ps
`default_nettype none
`include "aclr_cfg.svh"

module aclr_top_bench;

  // ==========================================================
  // Signals and reference model
  localparam logic [11:0] A_TSEL = {`ACLR_IDX_TSEL, 2'b00};
  localparam logic [11:0] A_OFF  = {`ACLR_IDX_OFFSET, 2'b00};
  localparam logic [11:0] A_DATA = {`ACLR_IDX_DATA, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h004;

  logic                                  i_clk;
  logic                                  i_nrst;
  logic                                  i_psel;
  logic                                  i_penable;
  logic                                  i_pwrite;
  logic [11:0]                           i_paddr;
  logic [31:0]                           i_pwdata;
  logic [3:0]                            i_pstrb;
  logic [31:0]                           o_prdata;
  logic                                  o_pready;
  logic                                  o_pslverr;
  aclr_pkg::aclr_rule_fields_t [4:0]     o_rule_fields;
  int                                    bad_count;
  int                                    cmp_count;
  logic [9:0]                            exp_q[$];
  logic [9:0]                            e;
  logic [7:0]                            mem [5][14];
  logic [3:0]                            badp [3] = '{4'h0, 4'h6, 4'hF};

  aclr_top #(.NPORTS(5)) dut (
    .i_clk         (i_clk),
    .i_nrst        (i_nrst),
    .i_psel        (i_psel),
    .i_penable     (i_penable),
    .i_pwrite      (i_pwrite),
    .i_paddr       (i_paddr),
    .i_pwdata      (i_pwdata),
    .i_pstrb       (i_pstrb),
    .o_prdata      (o_prdata),
    .o_pready      (o_pready),
    .o_pslverr     (o_pslverr),
    .o_rule_fields (o_rule_fields)
  );

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ==========================================================
  // Checking
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] x, input string m);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, m, g, x);
    end
  endtask

  task automatic chk_fields();
    aclr_pkg::aclr_rule_fields_t x;
    for (int p = 0; p < 5; p++) begin
      x.l4_mode = (mem[p][1][5:4] == 2'h2);
      x.l3_mask_low = {mem[p][8], mem[p][9]};
      x.upper_bound = {mem[p][2], mem[p][3]};
      x.lower_bound = {mem[p][4], mem[p][5]};
      x.range_compare_select = aclr_pkg::aclr_cmp_t'(mem[p][6][2:1]);
      cmp_count++;
      if (o_rule_fields[p] !== x) begin
        bad_count++;
        $display("[FAIL] %0t rule fields of port %0d differ", $time, p + 1);
      end
    end
  endtask

  // Reads result only in the one cycle pready stands
  always @(negedge i_clk) begin
    if (o_pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk32(32'h0000_0001, 32'h0000_0000, "unexpected pready");
      end else begin
        e = exp_q.pop_front();
        chk32({31'h0, o_pslverr}, {31'h0, e[8]}, "slave error");
        if (!e[9]) chk32(o_prdata, {24'h00_0000, e[7:0]}, "read data");
      end
    end
  end

  // ==========================================================
  // APB master and indirect access
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input logic [3:0] st,
                     input logic [7:0] ed, input logic ee);
    int          n;
    logic [31:0] rnd;
    rnd = $urandom();
    exp_q.push_back({wr, ee, ed});
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= {rnd[31:8], d};
    i_pstrb <= st;
    @(posedge i_clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (o_pready !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t no pready", $time);
      wrap_up();
    end else begin
      @(posedge i_clk);
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF, 8'h00, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00, 4'hF, x, 1'b0);
  endtask

  task automatic sel(input int p, input int o);
    wr(A_TSEL, {3'h2, 1'b0, p[3:0]});
    wr(A_OFF, o[7:0]);
  endtask

  // Byte 0x06 upper bits vanish only in layer-4 mode
  task automatic put(input int p, input int o, input logic [7:0] d);
    sel(p, o);
    wr(A_DATA, d);
    if (o == 6 && mem[p-1][1][5:4] == 2'h2) mem[p-1][o] = d & 8'h07;
    else mem[p-1][o] = d;
  endtask

  task automatic get(input int p, input int o);
    sel(p, o);
    if (o == 6 && mem[p-1][1][5:4] == 2'h2) rd(A_DATA, mem[p-1][o] & 8'h07);
    else rd(A_DATA, mem[p-1][o]);
  endtask

  task automatic all_get();
    for (int p = 1; p <= 5; p++)
      for (int o = 0; o < 14; o++) get(p, o);
    chk_fields();
  endtask

  task automatic do_reset();
    i_nrst <= 1'b0;
    foreach (mem[p, o]) mem[p][o] = 8'h00;
    repeat (6) @(posedge i_clk);
    i_nrst <= 1'b1;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    logic [7:0] d;
    i_nrst = 1'b0;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 12'h000;
    i_pwdata = 32'h0000_0000;
    i_pstrb = 4'h0;
    bad_count = 0;
    cmp_count = 0;
    void'($urandom(32'hB29D6D6C));
    do_reset();
    rd(A_TSEL, 8'h00);
    rd(A_OFF, 8'h00);
    all_get();
    for (int p = 1; p <= 5; p++) begin
      for (int o = 0; o < 14; o++) begin
        d = $urandom();
        if (o == 1) d[5:4] = p[0] ? 2'h2 : 2'h1;
        put(p, o, d);
      end
    end
    all_get();
    for (int m = 0; m < 4; m++) begin
      put(1, 6, {5'h1F, m[1:0], 1'b1});
      get(1, 6);
      chk_fields();
    end
    for (int t = 0; t < 8; t++) begin
      if (t == 2) continue;
      wr(A_TSEL, {t[2:0], 1'b0, 4'h1});
      wr(A_OFF, 8'h02);
      wr(A_DATA, 8'hA5);
      rd(A_DATA, 8'h00);
    end
    foreach (badp[i]) begin
      wr(A_TSEL, {3'h2, 1'b0, badp[i]});
      wr(A_OFF, 8'h02);
      wr(A_DATA, 8'h5A);
      rd(A_DATA, 8'h00);
    end
    for (int o = 14; o < 256; o += 241) begin
      sel(1, o);
      wr(A_DATA, 8'h3C);
      rd(A_DATA, 8'h00);
    end
    sel(2, 3);
    apb(1'b1, A_DATA, 8'hC3, 4'hE, 8'h00, 1'b0);
    apb(1'b1, A_BAD, 8'h11, 4'hF, 8'h00, 1'b1);
    apb(1'b0, A_BAD, 8'h00, 4'hF, 8'h00, 1'b1);
    wr(A_TSEL, 8'hFF);
    rd(A_TSEL, 8'hFF);
    wr(A_OFF, 8'hA5);
    rd(A_OFF, 8'hA5);
    all_get();
    // Second reset in mid-run must clear every entry again
    do_reset();
    rd(A_TSEL, 8'h00);
    rd(A_OFF, 8'h00);
    all_get();
    wrap_up();
  end

endmodule

`default_nettype wire
